// File: core_model.sv
// Behavioural core sequencer facing the interrupt unit
`timescale 1ns/1ns
module core_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        go_sleep,
  input  wire logic        go_ret,
  input  wire logic        core_wake,
  input  wire logic        core_vector,
  input  wire logic        ctx_restore,
  input  wire logic [7:0]  rest_w,
  output logic             core_sleep,
  output logic             core_instr_done,
  output logic             core_retfie,
  output logic      [14:0] core_pc,
  output logic      [7:0]  live_w,
  output logic      [7:0]  live_status,
  output logic      [4:0]  live_bsr,
  output logic      [15:0] live_fsr,
  output logic      [6:0]  live_pch
);
  logic asleep_q;
  assign live_status = live_w ^ 8'h18;
  assign live_bsr    = core_pc[4:0];
  assign live_fsr    = {live_w, ~live_w};
  assign live_pch    = core_pc[14:8];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      asleep_q        <= 1'b0;
      core_sleep      <= 1'b0;
      core_retfie     <= 1'b0;
      core_instr_done <= 1'b0;
      core_pc         <= 15'h0000;
      live_w          <= 8'h00;
    end else begin
      core_sleep  <= go_sleep;
      core_retfie <= go_ret;
      if (go_sleep)
        asleep_q <= 1'b1;
      else if (core_wake)
        asleep_q <= 1'b0;
      // Post-wake instruction runs first
      core_instr_done <= !asleep_q && !go_sleep && !core_instr_done;
      if (core_vector)
        core_pc <= 15'h0004;
      else if (core_instr_done)
        core_pc <= core_pc + 15'h0001;
      if (ctx_restore)
        live_w <= rest_w;
      else if (core_instr_done)
        live_w <= core_pc[7:0];
    end
  end
endmodule : core_model

// File: ctx_if.sv
// Context bundle between top and shadow store
`timescale 1ns/1ns
interface ctx_if;
  import irq_pkg::*;
  context_type live;
  context_type shadow;
  logic        save;
  logic        sw_we;
  logic [3:0]  sw_sel;
  logic [15:0] sw_data;
  modport store (input live, save, sw_we, sw_sel, sw_data, output shadow);
  modport user  (output live, save, sw_we, sw_sel, sw_data, input shadow);
endinterface : ctx_if

// File: irq_pkg.sv
// Shared constants for the interrupt wake and context unit
package irq_pkg;
  localparam logic [3:0] reg_ctrl_off    = 4'h0;
  localparam logic [3:0] reg_option_off  = 4'h1;
  localparam logic [3:0] reg_flags2_off  = 4'h2;
  localparam logic [3:0] reg_enable2_off = 4'h3;
  localparam logic [3:0] reg_sh_w_off    = 4'h4;
  localparam logic [3:0] reg_sh_stat_off = 4'h5;
  localparam logic [3:0] reg_sh_bsr_off  = 4'h6;
  localparam logic [3:0] reg_sh_fsr_off  = 4'h7;
  localparam logic [3:0] reg_sh_pch_off  = 4'h8;
  localparam logic [3:0] reg_irq_st_off  = 4'h9;
  localparam logic [3:0] reg_irq_en_off  = 4'ha;
  localparam logic [3:0] reg_irq_clr_off = 4'hb;
  localparam logic [3:0] reg_pc_off      = 4'hc;
  localparam int ctrl_gie_bit  = 7;
  localparam int ctrl_ext_pin_irq_enable_bit = 4;
  localparam int ctrl_ext_pin_irq_flag_bit = 1;
  localparam int opt_edge_bit  = 6;
  localparam logic [7:0] option_reset    = 8'hff;
  localparam logic [7:0] status_keep_mask = 8'he7;
  localparam logic [4:0] shadow_bank     = 5'h1f;
  localparam logic [7:0] wake_mask_reset = 8'hff;
  localparam logic [2:0] ev_ext  = 3'h0;
  localparam logic [2:0] ev_wake = 3'h1;
  localparam logic [2:0] ev_entry= 3'h2;
  localparam logic [2:0] ev_ret  = 3'h3;
  typedef struct packed {
    logic [7:0]  w;
    logic [7:0]  status;
    logic [4:0]  bank_select_reg;
    logic [15:0] indirect_pointer_regs;
    logic [6:0]  pch;
  } context_type;
  typedef enum logic [3:0] {
    st_run   = 4'b0001,
    st_sleep = 4'b0010,
    st_post  = 4'b0100,
    st_isr   = 4'b1000
  } seq_state_type;
endpackage : irq_pkg

// File: irq_unit_assertions.sv
// Port checker for the interrupt wake and context unit
`timescale 1ns/1ns
module irq_unit_checker
  import irq_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        core_instr_done,
  input wire logic [14:0] core_pc,
  input wire logic [7:0]  live_w,
  input wire logic [7:0]  live_status,
  input wire logic [4:0]  live_bsr,
  input wire logic [15:0] live_fsr,
  input wire logic [6:0]  live_pch,
  input wire logic        core_wake,
  input wire logic        core_vector,
  input wire logic        stack_push,
  input wire logic [14:0] stack_push_pc,
  input wire logic        ctx_restore,
  input wire logic [7:0]  rest_w,
  input wire logic [7:0]  rest_status,
  input wire logic [4:0]  rest_bsr,
  input wire logic [15:0] rest_fsr,
  input wire logic [6:0]  rest_pch,
  input wire logic [4:0]  shadow_bank_id
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Wake seen, post-sleep instruction not yet retired
  logic post_q;
  logic post_dn_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      post_q    <= 1'b0;
      post_dn_q <= 1'b0;
    end else begin
      post_dn_q <= (post_q || core_wake) && core_instr_done;
      if (core_wake) begin
        post_q <= 1'b1;
      end else if (post_dn_q) begin
        post_q <= 1'b0;
      end
    end
  end
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_vector_cause: assert property (core_vector |-> $past(core_instr_done))
    else $error("vector without finished instruction");
  chk_push_with_vector: assert property (core_vector |-> stack_push)
    else $error("vector without stack push");
  chk_push_pc: assert property (stack_push |-> stack_push_pc == $past(core_pc))
    else $error("pushed pc differs");
  chk_save_context: assert property (core_vector |-> ##1 (rest_w == $past(live_w, 2) &&
    (rest_status & status_keep_mask) == ($past(live_status, 2) & status_keep_mask)))
    else $error("context not saved");
  chk_save_rest: assert property (core_vector |-> ##1 (rest_bsr == $past(live_bsr, 2) &&
    rest_fsr == $past(live_fsr, 2) && rest_pch == $past(live_pch, 2) &&
    (rest_status & ~status_keep_mask) == ($past(rest_status) & ~status_keep_mask)))
    else $error("context fields not saved");
  chk_post_instr_first: assert property (core_vector |-> !post_q)
    else $error("vector before post-sleep instruction");
  chk_bank_fixed: assert property (!$past(rst) |-> shadow_bank_id == shadow_bank)
    else $error("shadow bank wrong");
  chk_wake_then_instr: assert property (core_wake |=> !core_vector)
    else $error("vector right after wake");
  cov_wake: cover property (core_wake);
  cov_vector: cover property (core_vector);
  cov_restore: cover property (ctx_restore);
endmodule : irq_unit_checker
bind irq_wake_context_unit irq_unit_checker chk (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .core_instr_done, .core_pc, .live_w, .live_status, .live_bsr, .live_fsr,
  .live_pch, .core_wake, .core_vector, .stack_push, .stack_push_pc, .ctx_restore, .rest_w,
  .rest_status, .rest_bsr, .rest_fsr, .rest_pch, .shadow_bank_id);

// File: irq_wake_context_unit.sv
// Interrupt front end: wake, pin edge, vectoring, context save and restore
// What this block does
// - Only clockless-capable sources, per wake mask, may wake the core from sleep.
// - On wake, vector if global enable set, else resume after sleep.
// - One instruction after sleep always runs before any vector branch.
// - Pin edge is caught asynchronously, independent of the clock.
// - Pin interrupt is enabled by its own enable bit; vectoring also needs global enable.
// - Edge select high picks rising edge, low picks falling edge.
// - A valid pin edge sets the pin interrupt flag.
// - Pin flag with both enables set redirects to the vector.
// - Interrupt entry pushes the return program counter on the stack.
// - Entry copies W, bank, pointers, PC high latch, status minus TO/PD.
// - Return restores all saved registers from shadows, discarding live edits.
// - Shadows sit in bank 31, readable and writable by software.
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
module irq_wake_context_unit
  import irq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        ext_pin,
  input  wire logic [7:0]  periph_event,
  input  wire logic [7:0]  periph_async_wake,
  input  wire logic        core_sleep,
  input  wire logic        core_instr_done,
  input  wire logic        core_retfie,
  input  wire logic [14:0] core_pc,
  input  wire logic [7:0]  live_w,
  input  wire logic [7:0]  live_status,
  input  wire logic [4:0]  live_bsr,
  input  wire logic [15:0] live_fsr,
  input  wire logic [6:0]  live_pch,
  output logic             core_wake,
  output logic             core_vector,
  output logic             stack_push,
  output logic      [14:0] stack_push_pc,
  output logic             ctx_restore,
  output logic      [7:0]  rest_w,
  output logic      [7:0]  rest_status,
  output logic      [4:0]  rest_bsr,
  output logic      [15:0] rest_fsr,
  output logic      [6:0]  rest_pch,
  output logic      [4:0]  shadow_bank_id,
  output logic             irq_o
);
  import irq_pkg::*;

  ctx_if ctx ();
  shadow_store u_shadow (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ctx     (ctx.store)
  );

  logic [7:0]    ctrl_q;
  logic [7:0]    option_q;
  logic [7:0]    flags2_q;
  logic [7:0]    enable2_q;
  logic [7:0]    wake_mask_q;
  logic [3:0]    ev_st_q;
  logic [3:0]    ev_en_q;
  seq_state_type state_q;
  logic          edge_tog_q;
  logic          edge_s1_q;
  logic          edge_s2_q;
  logic          edge_s3_q;
  logic          ack_q;
  logic [31:0]   rdat_q;
  logic          bus_req;
  logic          bus_wr;
  logic          ext_hit;
  logic          irq_req;
  logic          wake_req;
  logic          do_entry;
  logic          do_ret;
  logic [7:0]    wbyte;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];

  // Asynchronous pin edge capture, toggles per active edge
  logic edge_pin;
  assign edge_pin = option_q[opt_edge_bit] ? ext_pin : !ext_pin;
  always_ff @(posedge edge_pin or posedge rst) begin
    if (rst) begin
      edge_tog_q <= 1'b0;
    end else begin
      edge_tog_q <= !edge_tog_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      edge_s1_q <= 1'b0;
      edge_s2_q <= 1'b0;
      edge_s3_q <= 1'b0;
    end else begin
      edge_s1_q <= edge_tog_q;
      edge_s2_q <= edge_s1_q;
      edge_s3_q <= edge_s2_q;
    end
  end
  assign ext_hit = edge_s2_q ^ edge_s3_q;

  // Control register: flag set wins over software clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 8'h00;
    end else begin
      if (bus_wr && wb_adr_i == reg_ctrl_off) begin
        ctrl_q <= wbyte;
      end
      if (ext_hit) begin
        ctrl_q[ctrl_ext_pin_irq_flag_bit] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      option_q <= option_reset;
    end else if (bus_wr && wb_adr_i == reg_option_off) begin
      option_q <= wbyte;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags2_q <= 8'h00;
    end else begin
      if (bus_wr && wb_adr_i == reg_flags2_off) begin
        flags2_q <= wbyte | periph_event;
      end else begin
        flags2_q <= flags2_q | periph_event;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable2_q   <= 8'h00;
      wake_mask_q <= wake_mask_reset;
    end else if (bus_wr && wb_adr_i == reg_enable2_off) begin
      enable2_q <= wbyte;
    end else if (bus_wr && wb_adr_i == reg_pc_off) begin
      wake_mask_q <= wbyte;
    end
  end

  assign irq_req = ctrl_q[ctrl_gie_bit] &&
                   ((|(flags2_q & enable2_q)) ||
                    (ctrl_q[ctrl_ext_pin_irq_enable_bit] && ctrl_q[ctrl_ext_pin_irq_flag_bit]));

  // Wake needs enabled pending source able to run clockless
  assign wake_req = (|(flags2_q & enable2_q & periph_async_wake & wake_mask_q)) ||
                    (ctrl_q[ctrl_ext_pin_irq_enable_bit] && ctrl_q[ctrl_ext_pin_irq_flag_bit]);

  assign do_entry = (state_q == st_run) && irq_req && core_instr_done;
  assign do_ret   = (state_q == st_isr) && core_retfie;

  // Core sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= st_run;
    end else begin
      unique case (state_q)
        st_run: begin
          if (do_entry) begin
            state_q <= st_isr;
          end else if (core_sleep) begin
            state_q <= st_sleep;
          end
        end
        st_sleep: begin
          if (wake_req) begin
            state_q <= st_post;
          end
        end
        st_post: begin
          if (core_instr_done) begin
            state_q <= st_run;
          end
        end
        st_isr: begin
          if (core_retfie) begin
            state_q <= st_run;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_wake     <= 1'b0;
      core_vector   <= 1'b0;
      stack_push    <= 1'b0;
      stack_push_pc <= 15'h0000;
      ctx_restore   <= 1'b0;
    end else begin
      core_wake     <= (state_q == st_sleep) && wake_req;
      core_vector   <= do_entry;
      stack_push    <= do_entry;
      if (do_entry) begin
        stack_push_pc <= core_pc;
      end
      ctx_restore   <= do_ret;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rest_w      <= 8'h00;
      rest_status <= 8'h00;
      rest_bsr    <= 5'h00;
      rest_fsr    <= 16'h0000;
      rest_pch    <= 7'h00;
    end else begin
      rest_w      <= ctx.shadow.w;
      rest_status <= ctx.shadow.status;
      rest_bsr    <= ctx.shadow.bank_select_reg;
      rest_fsr    <= ctx.shadow.indirect_pointer_regs;
      rest_pch    <= ctx.shadow.pch;
    end
  end

  assign ctx.live    = '{w: live_w, status: live_status, bank_select_reg: live_bsr,
                         indirect_pointer_regs: live_fsr, pch: live_pch};
  assign ctx.save    = do_entry;
  assign ctx.sw_we   = bus_wr && (wb_adr_i >= reg_sh_w_off) &&
                       (wb_adr_i <= reg_sh_pch_off);
  assign ctx.sw_sel  = wb_adr_i;
  assign ctx.sw_data = wb_dat_i[15:0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shadow_bank_id <= 5'h00;
    end else begin
      shadow_bank_id <= shadow_bank;
    end
  end

  // Event status: set wins over clear
  logic [3:0] ev_set;
  assign ev_set = {do_ret, do_entry, core_wake, ext_hit};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev_st_q <= 4'h0;
      ev_en_q <= 4'h0;
    end else begin
      if (bus_wr && wb_adr_i == reg_irq_clr_off) begin
        ev_st_q <= (ev_st_q & ~wbyte[3:0]) | ev_set;
      end else begin
        ev_st_q <= ev_st_q | ev_set;
      end
      if (bus_wr && wb_adr_i == reg_irq_en_off) begin
        ev_en_q <= wbyte[3:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(ev_st_q & ev_en_q);
    end
  end

  // Wishbone read mux and single-wait ack
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req) begin
        unique case (wb_adr_i)
          reg_ctrl_off:    rdat_q <= {24'h0, ctrl_q};
          reg_option_off:  rdat_q <= {24'h0, option_q};
          reg_flags2_off:  rdat_q <= {24'h0, flags2_q};
          reg_enable2_off: rdat_q <= {24'h0, enable2_q};
          reg_sh_w_off:    rdat_q <= {24'h0, ctx.shadow.w};
          reg_sh_stat_off: rdat_q <= {24'h0, ctx.shadow.status};
          reg_sh_bsr_off:  rdat_q <= {27'h0, ctx.shadow.bank_select_reg};
          reg_sh_fsr_off:  rdat_q <= {16'h0, ctx.shadow.indirect_pointer_regs};
          reg_sh_pch_off:  rdat_q <= {25'h0, ctx.shadow.pch};
          reg_irq_st_off:  rdat_q <= {28'h0, ev_st_q};
          reg_irq_en_off:  rdat_q <= {28'h0, ev_en_q};
          reg_pc_off:      rdat_q <= {24'h0, wake_mask_q};
          default:         rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
endmodule : irq_wake_context_unit

// File: shadow_store.sv
// Shadow register bank for automatic context save
`timescale 1ns/1ns
module shadow_store
  import irq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  ctx_if.store     ctx
);
  import irq_pkg::*;
  context_type sh_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_q <= '0;
    end else if (ctx.save) begin
      sh_q.w      <= ctx.live.w;
      sh_q.status <= (ctx.live.status & status_keep_mask) |
                     (sh_q.status & ~status_keep_mask);
      sh_q.bank_select_reg    <= ctx.live.bank_select_reg;
      sh_q.indirect_pointer_regs    <= ctx.live.indirect_pointer_regs;
      sh_q.pch    <= ctx.live.pch;
    end else if (ctx.sw_we) begin
      unique case (ctx.sw_sel)
        reg_sh_w_off:    sh_q.w      <= ctx.sw_data[7:0];
        reg_sh_stat_off: sh_q.status <= ctx.sw_data[7:0];
        reg_sh_bsr_off:  sh_q.bank_select_reg    <= ctx.sw_data[4:0];
        reg_sh_fsr_off:  sh_q.indirect_pointer_regs    <= ctx.sw_data;
        reg_sh_pch_off:  sh_q.pch    <= ctx.sw_data[6:0];
        default: ;
      endcase
    end
  end
  assign ctx.shadow = sh_q;
endmodule : shadow_store

// File: tb_top.sv
// Self-checking bench for the interrupt wake and context unit
`timescale 1ns/1ns
module tb_top;
  import irq_pkg::*;
  logic        sys_clk = 0, rst = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic        ext_pin = 0, go_sleep = 0, go_ret = 0, wb_ack_o, irq_o;
  logic [3:0]  wb_adr_i = 0, wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, v;
  logic [7:0]  periph_event = 0, periph_async_wake = 0, live_w, live_status, rest_w;
  logic [14:0] core_pc;
  logic [4:0]  live_bsr;
  logic [15:0] live_fsr;
  logic [6:0]  live_pch;
  logic        core_sleep, core_instr_done, core_retfie, core_wake, core_vector, ctx_restore;
  logic [31:0] rd_q[$], ev_q[$];
  int          n_errors = 0, tests_run = 0, vec_cnt = 0, wake_cnt = 0, i, seed = 87;
  always #5 sys_clk = ~sys_clk;
  irq_wake_context_unit dut (.sys_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ext_pin, .periph_event, .periph_async_wake,
    .core_sleep, .core_instr_done, .core_retfie, .core_pc, .live_w, .live_status, .live_bsr,
    .live_fsr, .live_pch, .core_wake, .core_vector, .stack_push(), .stack_push_pc(),
    .ctx_restore, .rest_w, .rest_status(), .rest_bsr(), .rest_fsr(), .rest_pch(),
    .shadow_bank_id(), .irq_o);
  core_model core (.sys_clk, .rst, .go_sleep, .go_ret, .core_wake, .core_vector, .ctx_restore,
    .rest_w, .core_sleep, .core_instr_done, .core_retfie, .core_pc, .live_w, .live_status,
    .live_bsr, .live_fsr, .live_pch);
  task complete_run;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task acc(input logic we, input logic [3:0] sel, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, we, sel, a, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : acc
  task wr(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, 4'hf, a, d);
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    acc(1'b0, 4'hf, a, 32'h0);
  endtask : rd
  task pulse(input int b);
    @(posedge sys_clk);
    periph_event <= 8'h01 << b;
    @(posedge sys_clk);
    periph_event <= 8'h00;
  endtask : pulse
  task core_cmd(input logic s);
    @(posedge sys_clk);
    {go_sleep, go_ret} <= {s, !s};
    @(posedge sys_clk);
    {go_sleep, go_ret} <= 2'b00;
  endtask : core_cmd
  task wait_cnt(input logic w, input int n);
    int k;
    for (k = 0; k < 80 && (w ? wake_cnt : vec_cnt) < n; k++) @(posedge sys_clk);
    check(k < 80, 1);
  endtask : wait_cnt
  always @(posedge sys_clk) begin
    if (core_vector === 1'b1) vec_cnt++;
    if (core_wake === 1'b1) wake_cnt++;
    if (wb_ack_o === 1'b1 && !wb_we_i && rd_q.size() > 0) check(wb_dat_o, rd_q.pop_front());
    if (ctx_restore === 1'b1 && ev_q.size() > 0) check({24'h0, rest_w}, ev_q.pop_front());
  end
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd(reg_option_off, 32'hff);
    rd(reg_pc_off, 32'hff);
    rd(reg_flags2_off, 32'h0);
    rd(4'hd, 32'h0);
    for (i = 0; i < 8; i++) begin
      pulse(i);
      repeat (3) @(posedge sys_clk);
      rd(reg_flags2_off, (32'h2 << i) - 1);
    end
    acc(1'b1, 4'h0, reg_flags2_off, 32'h0);
    rd(reg_flags2_off, 32'hff);
    wr(reg_flags2_off, 32'h0);
    rd(reg_flags2_off, 32'h0);
    // Event interrupt: raise, mask, clear
    wr(reg_irq_en_off, 32'h1);
    ext_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(reg_ctrl_off, 32'h2);
    check(irq_o, 1);
    wr(reg_irq_en_off, 32'h0);
    repeat (2) @(posedge sys_clk);
    check(irq_o, 0);
    wr(reg_irq_clr_off, 32'h1);
    wr(reg_irq_en_off, 32'h1);
    rd(reg_irq_st_off, 32'h0);
    check(irq_o, 0);
    wr(reg_ctrl_off, 32'h0);
    wr(reg_option_off, 32'hbf);
    ext_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(reg_ctrl_off, 32'h2);
    wr(reg_ctrl_off, 32'h0);
    ext_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(reg_ctrl_off, 32'h0);
    ext_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wr(reg_ctrl_off, 32'h82);
    repeat (20) @(posedge sys_clk);
    check(vec_cnt, 0);
    wr(reg_ctrl_off, 32'h92);
    wait_cnt(1'b0, 1);
    rd(reg_ctrl_off, 32'h92);
    wr(reg_ctrl_off, 32'h90);
    v = {24'h0, 8'($random(seed))};
    wr(reg_sh_w_off, v);
    rd(reg_sh_w_off, v);
    wr(reg_sh_fsr_off, v << 8);
    rd(reg_sh_fsr_off, v << 8);
    ev_q.push_back(v);
    core_cmd(1'b0);
    repeat (6) @(posedge sys_clk);
    check(ev_q.size(), 0);
    rd(reg_irq_st_off, 32'hd);
    // Sleep: wake needs a clockless source
    wr(reg_ctrl_off, 32'h0);
    wr(reg_enable2_off, 32'h1);
    core_cmd(1'b1);
    pulse(0);
    repeat (20) @(posedge sys_clk);
    check(wake_cnt, 0);
    wr(reg_pc_off, 32'h0);
    periph_async_wake <= 8'h01;
    repeat (20) @(posedge sys_clk);
    check(wake_cnt, 0);
    wr(reg_flags2_off, 32'h0);
    wr(reg_pc_off, 32'hff);
    pulse(0);
    wait_cnt(1'b1, 1);
    repeat (10) @(posedge sys_clk);
    check(vec_cnt, 1);
    wr(reg_flags2_off, 32'h0);
    wr(reg_ctrl_off, 32'h80);
    core_cmd(1'b1);
    pulse(0);
    wait_cnt(1'b1, 2);
    wait_cnt(1'b0, 2);
    rd(reg_irq_st_off, 32'hf);
    wr(reg_irq_clr_off, 32'hf);
    rd(reg_irq_st_off, 32'h0);
    repeat (2) @(posedge sys_clk);
    check(rd_q.size(), 0);
    complete_run();
  end
endmodule : tb_top
